// ### hdl/xbar_pkg.sv
// Package with types and constants shared by the crossbar arbiter.
package xbar_pkg;

    // Master indices; lower index wins a conflict.
    localparam int MASTER_ACCEL = 0;
    localparam int MASTER_HOST = 1;
    localparam int MASTER_CORE = 2;
    localparam int NUM_MASTERS = 3;

    // Target indices: on-chip memory, then the peripheral targets.
    localparam int TARGET_MEMORY = 0;
    localparam int TARGET_PERIPH_FIRST = 1;
    localparam int NUM_TARGETS = 4;

    // Memory port widths of the four request sources.
    localparam int CORE_DATA_WIDTH = 64;
    localparam int FETCH_WIDTH = 256;
    localparam int SYSTEM_WIDTH = 32;
    localparam int NUM_MEM_SOURCES = 4;
    localparam int MAX_PARALLEL_MEM = 3;

    // Host page window: 64K bytes, so the page number is the upper 16 bits.
    localparam int ADDR_WIDTH = 32;
    localparam int PAGE_SHIFT = 16;
    localparam int PAGE_WIDTH = 16;
    localparam logic [15:0] PAGE_RESET = 16'h0000;

    // Request carried by each crossbar master.
    typedef struct packed {
        logic valid;
        logic [1:0] target;
        logic [31:0] addr;
    } xbar_req_t;

    // Arbiter state of one target.
    typedef enum logic [1:0] {
        TGT_IDLE = 2'b01,
        TGT_BUSY = 2'b10
    } tgt_state_t;

endpackage

// ### hdl/crossbar_priority_arbiter.sv
// Crossbar arbiter with on-chip memory port scheduler and host page window.
// How it works
// - Non-conflicting masters proceed in parallel.
// - Conflict priority: accelerator, host port, core.
// - No path from host port to peripherals.
// - Memory serves up to three accesses together.
// - Sources: two core data, fetch, shared system.
// - Core data access completes in one cycle.
// - Host page set only by core.
`timescale 1ns/1ps
module crossbar_priority_arbiter #(
    parameter int NUM_MASTERS = xbar_pkg::NUM_MASTERS,
    parameter int NUM_TARGETS = xbar_pkg::NUM_TARGETS
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire xbar_pkg::xbar_req_t req_i [NUM_MASTERS],
    input wire logic [NUM_TARGETS-1:0] done_i,
    output logic [NUM_MASTERS-1:0] grant_o,
    output logic [NUM_MASTERS-1:0] stall_o,
    output logic [NUM_MASTERS-1:0] refused_o,
    output logic [31:0] host_addr_o,
    input wire logic host_page_en_i,
    input wire logic page_wr_core_i,
    input wire logic page_wr_host_i,
    input wire logic [15:0] page_wdata_i,
    output logic [15:0] host_page_o,
    input wire logic [xbar_pkg::NUM_MEM_SOURCES-1:0] mem_req_i,
    output logic [xbar_pkg::NUM_MEM_SOURCES-1:0] mem_grant_o,
    output logic [xbar_pkg::NUM_MEM_SOURCES-1:0] mem_ack_o
);

    // Owner of each target, one-hot over masters.
    logic [NUM_MASTERS-1:0] owner [NUM_TARGETS];
    // State of each target.
    xbar_pkg::tgt_state_t tstate [NUM_TARGETS];
    // Combinational winner per target in the current cycle.
    logic [NUM_MASTERS-1:0] next_owner [NUM_TARGETS];
    // Legal request seen by each target, per master.
    logic [NUM_MASTERS-1:0] want [NUM_TARGETS];
    // Page register for the host window.
    logic [15:0] host_page;

    // Per target: legal request collection and fixed-priority pick.
    for (genvar t = 0; t < NUM_TARGETS; t++) begin : g_tgt
        for (genvar m = 0; m < NUM_MASTERS; m++) begin : g_want
            // The host port never reaches a peripheral target.
            assign want[t][m] = req_i[m].valid && (int'(req_i[m].target) == t)
                && !(m == xbar_pkg::MASTER_HOST && t >= xbar_pkg::TARGET_PERIPH_FIRST);
        end

        // Lowest index wins: accelerator, then host port, then core.
        always_comb begin
            next_owner[t] = '0;
            if (want[t][xbar_pkg::MASTER_ACCEL]) begin
                next_owner[t][xbar_pkg::MASTER_ACCEL] = 1'b1;
            end else if (want[t][xbar_pkg::MASTER_HOST]) begin
                next_owner[t][xbar_pkg::MASTER_HOST] = 1'b1;
            end else if (want[t][xbar_pkg::MASTER_CORE]) begin
                next_owner[t][xbar_pkg::MASTER_CORE] = 1'b1;
            end else begin
                next_owner[t] = '0;
            end
        end

        // Hold the owner until the target signals completion; losers wait.
        always_ff @(posedge clk_i or posedge reset_i) begin
            if (reset_i) begin
                tstate[t] <= xbar_pkg::TGT_IDLE;
                owner[t] <= '0;
            end else begin
                case (tstate[t])
                    xbar_pkg::TGT_IDLE: begin
                        if (|next_owner[t]) begin
                            owner[t] <= next_owner[t];
                            tstate[t] <= xbar_pkg::TGT_BUSY;
                        end
                    end
                    xbar_pkg::TGT_BUSY: begin
                        // Completion frees the target without aborting anyone.
                        if (done_i[t]) begin
                            owner[t] <= '0;
                            tstate[t] <= xbar_pkg::TGT_IDLE;
                        end
                    end
                    default: begin
                        tstate[t] <= xbar_pkg::TGT_IDLE;
                        owner[t] <= '0;
                    end
                endcase
            end
        end
    end

    // Grants and stalls per master; targets are independent of one another.
    always_comb begin
        grant_o = '0;
        stall_o = '0;
        refused_o = '0;
        for (int m = 0; m < NUM_MASTERS; m++) begin
            for (int t = 0; t < NUM_TARGETS; t++) begin
                if (owner[t][m]) begin
                    grant_o[m] = 1'b1;
                end
            end
            // A master with a request and no grant is held stalled.
            stall_o[m] = req_i[m].valid && !grant_o[m];
            refused_o[m] = (m == xbar_pkg::MASTER_HOST) && req_i[m].valid
                && (req_i[m].target >= 2'(xbar_pkg::TARGET_PERIPH_FIRST));
        end
    end

    // Host page register: only the core writes it; host writes are dropped.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            host_page <= xbar_pkg::PAGE_RESET;
        end else if (page_wr_core_i) begin
            host_page <= page_wdata_i;
        end
    end

    // Host address confined to the selected 64K page when enabled.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            host_addr_o <= '0;
        end else if (host_page_en_i) begin
            host_addr_o <= {host_page,
                req_i[xbar_pkg::MASTER_HOST].addr[xbar_pkg::PAGE_SHIFT-1:0]};
        end else begin
            host_addr_o <= req_i[xbar_pkg::MASTER_HOST].addr;
        end
    end

    assign host_page_o = host_page;

    // Memory scheduler: sources are core data A, core data B, fetch, system.
    // At most three are granted; the system port yields when all four ask.
    always_comb begin
        mem_grant_o = mem_req_i;
        if (&mem_req_i) begin
            mem_grant_o[3] = 1'b0;
        end
    end

    // Acknowledge one cycle after grant, so a core access takes one cycle.
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_ack_o <= '0;
        end else begin
            mem_ack_o <= mem_grant_o;
        end
    end

    // Checks.
    a_mem_max_three: assert property (@(posedge clk_i) disable iff (reset_i)
        $countones(mem_grant_o) <= xbar_pkg::MAX_PARALLEL_MEM)
        else $error("more than three memory grants");
    // A core data request is never dropped, so it must finish in the next cycle.
    a_core_one_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
        mem_req_i[0] |=> mem_ack_o[0])
        else $error("core data access not acked next cycle");
    // The second core data port has the same single-cycle promise.
    a_core_b_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
        mem_req_i[1] |=> mem_ack_o[1])
        else $error("second core data access not acked next cycle");
    a_host_no_periph: assert property (@(posedge clk_i) disable iff (reset_i)
        !owner[1][xbar_pkg::MASTER_HOST] && !owner[2][xbar_pkg::MASTER_HOST]
        && !owner[3][xbar_pkg::MASTER_HOST])
        else $error("host port owns a peripheral");
    a_accel_first_pick: assert property (@(posedge clk_i) disable iff (reset_i)
        (tstate[0] == xbar_pkg::TGT_IDLE && want[0][xbar_pkg::MASTER_ACCEL])
        |=> owner[0][xbar_pkg::MASTER_ACCEL])
        else $error("accelerator lost memory conflict");
    a_host_over_core: assert property (@(posedge clk_i) disable iff (reset_i)
        (tstate[0] == xbar_pkg::TGT_IDLE && !want[0][0] && want[0][1] && want[0][2])
        |=> owner[0][xbar_pkg::MASTER_HOST])
        else $error("core beat host port");
    a_page_host_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
        (page_wr_host_i && !page_wr_core_i) |=> $stable(host_page))
        else $error("host changed its page");
    a_page_core_write: assert property (@(posedge clk_i) disable iff (reset_i)
        page_wr_core_i |=> host_page == $past(page_wdata_i))
        else $error("core page write lost");
    a_owner_held: assert property (@(posedge clk_i) disable iff (reset_i)
        (tstate[0] == xbar_pkg::TGT_BUSY && !done_i[0]) |=> $stable(owner[0]))
        else $error("owner changed before completion");
    a_parallel_grant: assert property (@(posedge clk_i) disable iff (reset_i)
        (tstate[0] == xbar_pkg::TGT_IDLE && tstate[1] == xbar_pkg::TGT_IDLE
        && want[0][2] && !want[0][0] && !want[0][1] && want[1][0])
        |=> grant_o[2] && grant_o[0])
        else $error("independent transfers not parallel");

    // Steps of one memory transfer: a claim while idle, then completion while busy.
    sequence s_mem_claim;
        tstate[0] == xbar_pkg::TGT_IDLE && (|next_owner[0]);
    endsequence
    sequence s_mem_finish;
        tstate[0] == xbar_pkg::TGT_BUSY && done_i[0];
    endsequence

    // A claim makes the target busy with exactly the master that was picked.
    a_claim_takes_owner: assert property (@(posedge clk_i) disable iff (reset_i)
        s_mem_claim |=> tstate[0] == xbar_pkg::TGT_BUSY
        && owner[0] == $past(next_owner[0]))
        else $error("memory claim did not take its owner");
    // Completion frees the target; the next claim waits for the idle cycle.
    a_done_frees: assert property (@(posedge clk_i) disable iff (reset_i)
        s_mem_finish |=> tstate[0] == xbar_pkg::TGT_IDLE && owner[0] == '0)
        else $error("memory target not freed after completion");
    // A host request to a peripheral is stalled and never granted.
    a_refused_stalls: assert property (@(posedge clk_i) disable iff (reset_i)
        refused_o[xbar_pkg::MASTER_HOST] |-> stall_o[xbar_pkg::MASTER_HOST]
        && !grant_o[xbar_pkg::MASTER_HOST])
        else $error("refused host request was granted");
    // With the window on, the upper half of the host address is the page.
    a_host_window: assert property (@(posedge clk_i) disable iff (reset_i)
        host_page_en_i |=> host_addr_o == {$past(host_page),
        $past(req_i[xbar_pkg::MASTER_HOST].addr[xbar_pkg::PAGE_SHIFT-1:0])})
        else $error("host address left its page");
    // With the window off, the host address passes through unchanged.
    a_host_raw: assert property (@(posedge clk_i) disable iff (reset_i)
        !host_page_en_i |=> host_addr_o == $past(req_i[xbar_pkg::MASTER_HOST].addr))
        else $error("host address altered without window");
    // Fewer than four memory requests are all served together.
    a_mem_all_served: assert property (@(posedge clk_i) disable iff (reset_i)
        !(&mem_req_i) |-> mem_grant_o == mem_req_i)
        else $error("memory request left out below the limit");
    // When all four ask, the shared system port is the one that waits.
    a_system_yields: assert property (@(posedge clk_i) disable iff (reset_i)
        (&mem_req_i) |-> mem_grant_o == 4'h7)
        else $error("wrong memory source left out");
    // No memory source is granted without asking.
    a_grant_needs_req: assert property (@(posedge clk_i) disable iff (reset_i)
        (mem_grant_o & ~mem_req_i) == 4'h0)
        else $error("memory grant without request");

endmodule // crossbar_priority_arbiter

// ### verif/master_model.sv
// Behavioural model of the three crossbar masters.
`timescale 1ns/1ps
module master_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [2:0] go_i,
    input wire logic [5:0] tgt_i,
    input wire logic [31:0] addr_i,
    input wire logic [2:0] grant_i,
    output xbar_pkg::xbar_req_t req_o [3],
    output logic [3:0] done_o
);
    int cnt [3]; // Cycles each master has owned its target.
    // A master holds its request until granted, then ends after four owned cycles.
    always @(negedge clk_i or posedge reset_i) begin
        done_o <= 4'h0;
        for (int m = 0; m < 3; m++) begin
            if (reset_i) begin
                req_o[m] <= '0;
            end else if (go_i[m]) begin
                req_o[m] <= '{1'b1, tgt_i[2*m +: 2], addr_i};
                cnt[m] <= 0;
            end else if (req_o[m].valid && grant_i[m]) begin
                cnt[m] <= cnt[m] + 1;
                if (cnt[m] == 3) begin
                    done_o[req_o[m].target] <= 1'b1;
                    req_o[m].valid <= 1'b0;
                end
            end
        end
    end
endmodule // master_model

// ### verif/crossbar_priority_arbiter_tb.sv
// Self-checking bench for the crossbar arbiter.
`timescale 1ns/1ps
module crossbar_priority_arbiter_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b0;
    xbar_pkg::xbar_req_t req [3];
    logic [3:0] done;
    logic [2:0] grant, stall, refused, go = 3'h0;
    logic [5:0] tgt = 6'h00;
    logic [31:0] addr = 32'h0, host_addr, seed = 32'h0000001c;
    logic page_en = 1'b0, wr_core = 1'b0, wr_host = 1'b0;
    logic [15:0] wdata = 16'h0, host_page, page;
    logic [3:0] mem_req = 4'h0, mem_grant, mem_ack;
    int fail_count = 0, num_checks = 0, cycles = 0;

    crossbar_priority_arbiter i_dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req),
        .done_i(done), .grant_o(grant), .stall_o(stall), .refused_o(refused),
        .host_addr_o(host_addr), .host_page_en_i(page_en), .page_wr_core_i(wr_core),
        .page_wr_host_i(wr_host), .page_wdata_i(wdata), .host_page_o(host_page),
        .mem_req_i(mem_req), .mem_grant_o(mem_grant), .mem_ack_o(mem_ack));
    master_model i_masters (.clk_i(clk_i), .reset_i(reset_i), .go_i(go), .tgt_i(tgt),
        .addr_i(addr), .grant_i(grant), .req_o(req), .done_o(done));

    // Free-running 25 MHz clock.
    initial begin
        forever #20 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // The system port loses when all four memory sources ask at once.
    function automatic logic [3:0] mem_expect(input logic [3:0] r);
        return (r == 4'hf) ? 4'h7 : r;
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Starts requests; returns at the first falling edge where a grant can show.
    task automatic launch(input logic [2:0] mask, input logic [5:0] t, input logic [31:0] a);
        go <= mask;
        tgt <= t;
        addr <= a;
        @(negedge clk_i);
        go <= 3'h0;
        @(negedge clk_i);
    endtask

    task automatic wait_grant(input logic [2:0] mask);
        for (int i = 0; i < 20 && grant !== mask; i++) @(negedge clk_i);
    endtask

    task automatic do_reset();
        reset_i <= 1'b1;
        repeat (6) @(negedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cuts a hang short.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        do_reset();
        // All three masters meet on memory; losers stall until their turn.
        launch(3'h7, 6'h00, 32'h40);
        check("grant", grant, 3'h1);
        check("stall", stall, 3'h6);
        check("host_addr", host_addr, 32'h40);
        wait_grant(3'h2);
        check("grant", grant, 3'h2);
        check("stall", stall, 3'h4);
        wait_grant(3'h4);
        check("grant", grant, 3'h4);
        wait_grant(3'h0);
        // Accelerator on a peripheral and core on memory run side by side.
        launch(3'h5, 6'h01, 32'h80);
        check("grant", grant, 3'h5);
        check("stall", stall, 3'h0);
        wait_grant(3'h0);
        $display("arbitration tests done");
        // Host page writes are ignored; the core's write shapes host addresses.
        seed = xorshift(seed);
        page = seed[31:16];
        wdata <= page;
        wr_host <= 1'b1;
        @(negedge clk_i);
        wr_host <= 1'b0;
        wr_core <= 1'b1;
        check("page", host_page, 16'h0000);
        @(negedge clk_i);
        wr_core <= 1'b0;
        page_en <= 1'b1;
        wdata <= ~page;
        wr_host <= 1'b1;
        launch(3'h2, 6'h00, seed);
        wr_host <= 1'b0;
        @(negedge clk_i);
        check("page", host_page, page);
        check("host_addr", host_addr, {page, seed[15:0]});
        wait_grant(3'h0);
        // Host to a peripheral has no path and is never granted.
        launch(3'h2, 6'h08, 32'h0);
        check("refused", refused, 3'h2);
        repeat (4) @(negedge clk_i);
        check("grant", grant, 3'h0);
        do_reset();
        $display("host tests done");
        // Memory sources at random, starting with all four asking.
        for (int i = 0; i < 40; i++) begin
            seed = xorshift(seed);
            mem_req <= (i == 0) ? 4'hf : seed[3:0];
            @(negedge clk_i);
            check("mem_grant", mem_grant, mem_expect(mem_req));
            check("mem_ack", mem_ack, mem_expect(mem_req));
            check("mem_core", mem_grant[2:0], mem_req[2:0]);
        end
        $display("memory test done");
        finish_test();
    end
endmodule // crossbar_priority_arbiter_tb
